// ===== verilog/svm_defs.vh
`ifndef SVM_DEFS_VH
`define SVM_DEFS_VH

// Clock and slew timing.
`define SVM_CLK_NS         20
`define SVM_BASE_NS        2000
`define SVM_BASE_KOHM      30
`define SVM_RMIN_KOHM      8'h0f
`define SVM_RMAX_KOHM      8'h96
`define SVM_BASE_CYC       (`SVM_BASE_NS / `SVM_CLK_NS)
`define SVM_BLANK_TICKS    5'h18
`define SVM_FALL_SYNC      2'h2
`define SVM_PG_DELAY_US    3000
`define SVM_PG_DELAY_CYC   ((`SVM_PG_DELAY_US * 1000) / `SVM_CLK_NS)

// Multi-level pin encodings.
`define SVM_LVL_GND        2'h0
`define SVM_LVL_REF        2'h1
`define SVM_LVL_OPEN       2'h2
`define SVM_LVL_VCC        2'h3
`define SVM_SUS_GND        2'h0
`define SVM_SUS_REF        2'h1
`define SVM_SUS_HIGH       2'h2
`define SVM_OFS_NONE       2'h0

// Suspend code bases, upper and lower range.
`define SVM_SUS_HI_BASE    6'h18
`define SVM_SUS_LO_BASE    6'h08

// Register map, byte offsets.
`define SVM_REG_STATUS     4'h0
`define SVM_REG_LEVEL      4'h4
`define SVM_REG_CTRL       4'h8
`define SVM_CTRL_NOFAULT   0
`define SVM_CTRL_RESET     32'h0000_0000

`endif

// ===== verilog/svm_slew_tick.v
`timescale 1ns/100ps
`default_nettype none
`include "svm_defs.vh"

module svm_slew_tick
(
   input  wire        clk,
   input  wire        rst,
   input  wire [7:0]  resistor_kohm,
   output reg         tick
);

   ////////////////////////////////////////////////////////////////////////////
   reg  [7:0]  r_clamped;
   wire [15:0] product;
   wire [15:0] period;
   reg  [15:0] count;

   // Sized copies keep the period arithmetic at sixteen bits.
   localparam [15:0] BASE_CYC  = `SVM_BASE_CYC;
   localparam [15:0] BASE_KOHM = `SVM_BASE_KOHM;

   always @*
   begin
      if (resistor_kohm < `SVM_RMIN_KOHM)
         r_clamped = `SVM_RMIN_KOHM;
      else if (resistor_kohm > `SVM_RMAX_KOHM)
         r_clamped = `SVM_RMAX_KOHM;
      else
         r_clamped = resistor_kohm;
   end

   assign product = {8'h00, r_clamped} * BASE_CYC;
   assign period  = product / BASE_KOHM;

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         count <= 16'h0000;
         tick  <= 1'b0;
      end
      else if (count >= period - 16'h0001)
      begin
         count <= 16'h0000;
         tick  <= 1'b1;
      end
      else
      begin
         count <= count + 16'h0001;
         tick  <= 1'b0;
      end
   end

endmodule // svm_slew_tick

`default_nettype wire

// ===== verilog/svm_sus_decode.v
`timescale 1ns/100ps
`default_nettype none
`include "svm_defs.vh"

module svm_sus_decode
(
   input  wire [1:0]  suspend_select,
   input  wire [3:0]  suspend_code_sel,
   output reg  [5:0]  sus_code
);

   ////////////////////////////////////////////////////////////////////////////
   // Range picked by suspend level.
   always @*
   begin
      case (suspend_select)
         `SVM_SUS_REF:  sus_code = `SVM_SUS_HI_BASE + {2'b00, suspend_code_sel};
         `SVM_SUS_HIGH: sus_code = `SVM_SUS_LO_BASE + {2'b00, suspend_code_sel};
         default:       sus_code = `SVM_SUS_LO_BASE + {2'b00, suspend_code_sel};
      endcase
   end

endmodule // svm_sus_decode

`default_nettype wire

// ===== verilog/svm_vid_slew_mode_controller.v
`timescale 1ns/100ps
`default_nettype none
`include "svm_defs.vh"

//Contract
// - Startup target from vid or suspend decoder.
// - Vid change starts controlled transition.
// - Power-down forces low gate, high off.
// - Forced PWM, no offset, in normal.
// - Skip select: pulse skipping, upper pg blanked.
// - Offset window selects deep sleep offset.
// - Suspend overrides target, offset amplifier off.
// - Fault latch holds output until toggle.
// - Four-level static inputs, open is decoded.
// - Suspend level selects upper/lower range.
// - Suspend transition blanks pg and UV.
// - Pg frozen until 24 ticks after final.
// - One step per slew tick.
// - Falling transitions add two ticks.
// - Slew tick period from resistor.
// - Step period spans 1us to 10us.
// - Power-up quarter rate, pg 3ms delay.
// - Power-down drops pg, ramps to zero.
// - Undervoltage faults when not blanked.
module svm_vid_slew_mode_controller
#(
   parameter [17:0] PG_DELAY_CYC = `SVM_PG_DELAY_CYC
)
(
   input  wire        clk,
   input  wire        rst,
   input  wire        power_down_n,
   input  wire [5:0]  vid_code,
   input  wire [1:0]  suspend_select,
   input  wire [3:0]  suspend_code_sel,
   input  wire [1:0]  on_time_select,
   input  wire [1:0]  pulse_skip_select,
   input  wire [1:0]  offset_input,
   input  wire [7:0]  slew_rate_resistor,
   input  wire        pg_low_ok,
   input  wire        pg_high_ok,
   input  wire        undervoltage_detect,
   input  wire        overvoltage_detect,
   input  wire        thermal_detect,
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   output reg  [5:0]  dac_level,
   output reg         regulator_enable,
   output reg         low_side_gate,
   output reg         high_side_gate,
   output reg         power_good,
   output reg         pulse_skip,
   output reg         pg_upper_blank,
   output reg         offset_enable,
   output reg  [1:0]  offset_window,
   output reg  [1:0]  on_time_mode,
   output reg         undervoltage_protect,
   output reg         fault_latched
);

   ////////////////////////////////////////////////////////////////////////////
   localparam [3:0] ST_OFF   = 4'b0001;
   localparam [3:0] ST_START = 4'b0010;
   localparam [3:0] ST_RUN   = 4'b0100;
   localparam [3:0] ST_DOWN  = 4'b1000;

   reg  [3:0]  state;
   reg  [3:0]  next_state;
   reg  [5:0]  level;
   reg  [5:0]  next_level;
   reg  [4:0]  blank_cnt;
   reg  [4:0]  next_blank_cnt;
   reg  [1:0]  fall_wait;
   reg  [1:0]  next_fall_wait;
   reg  [1:0]  quarter;
   reg  [17:0] pg_timer;
   reg  [17:0] next_pg_timer;
   reg         nofault;
   wire        tick;
   wire        qtick;
   wire [5:0]  sus_code;
   wire [5:0]  target;
   wire        suspend;
   wire        moving;
   wire        blanked;
   wire        uv_fault;
   wire        hw_fault;
   wire        pg_eval;
   wire [31:0] status_word;

   ////////////////////////////////////////////////////////////////////////////
   // Slew tick divider.
   svm_slew_tick u_tick
   (
      .clk           (clk),
      .rst           (rst),
      .resistor_kohm (slew_rate_resistor),
      .tick          (tick)
   );

   svm_sus_decode u_sus
   (
      .suspend_select   (suspend_select),
      .suspend_code_sel (suspend_code_sel),
      .sus_code         (sus_code)
   );

   // Quarter rate for soft start and soft shutdown.
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         quarter <= 2'h0;
      else if (tick)
         quarter <= quarter + 2'h1;
   end
   assign qtick = tick & (quarter == 2'h3);

   // Suspend wins over the vid code and the offset input.
   assign suspend = (suspend_select != `SVM_SUS_GND);
   assign target  = suspend ? sus_code : vid_code;

   // Transition or tail blanking freezes pg.
   assign moving  = (level != target);
   assign blanked = moving | (blank_cnt != 5'h00);

   // Undervoltage only outside transitions and tail.
   // Suspend transitions share the same blanking.
   assign uv_fault = state[2] & ~blanked & undervoltage_detect & ~nofault;
   assign hw_fault = ~nofault & (overvoltage_detect | thermal_detect | uv_fault);

   // Upper pg threshold ignored in skip mode.
   assign pg_eval = pg_low_ok & (pulse_skip | pg_high_ok);

   ////////////////////////////////////////////////////////////////////////////
   always @*
   begin
      next_state     = state;
      next_level     = level;
      next_blank_cnt = blank_cnt;
      next_fall_wait = fall_wait;
      next_pg_timer  = (pg_timer != 18'h0_0000) ? pg_timer - 18'h0_0001 : pg_timer;
      case (state)
         ST_OFF:
         begin
            next_level = 6'h00;
            if (power_down_n & ~fault_latched)
               next_state = ST_START;
         end
         ST_START:
         begin
            if (~power_down_n | hw_fault)
               next_state = ST_DOWN;
            // Ramp up from zero at quarter rate.
            else if (~moving)
            begin
               next_state     = ST_RUN;
               next_pg_timer  = PG_DELAY_CYC;
               next_blank_cnt = `SVM_BLANK_TICKS;
            end
            else if (qtick)
               next_level = (level < target) ? level + 6'h01 : level - 6'h01;
         end
         ST_RUN:
         begin
            if (~power_down_n | hw_fault)
               next_state = ST_DOWN;
            else if (tick)
            begin
               // Target changes just redirect the steps.
               if (level < target)
               begin
                  next_level     = level + 6'h01;
                  next_fall_wait = 2'h0;
                  if (level + 6'h01 == target)
                     next_blank_cnt = `SVM_BLANK_TICKS;
               end
               else if (level > target)
               begin
                  if (fall_wait != `SVM_FALL_SYNC)
                     next_fall_wait = fall_wait + 2'h1;
                  else
                  begin
                     next_level = level - 6'h01;
                     if (level - 6'h01 == target)
                        next_blank_cnt = `SVM_BLANK_TICKS;
                  end
               end
               else
               begin
                  next_fall_wait = 2'h0;
                  // Tail of 24 ticks after final code.
                  if (blank_cnt != 5'h00)
                     next_blank_cnt = blank_cnt - 5'h01;
               end
            end
         end
         ST_DOWN:
         begin
            // Ramp to zero in single steps.
            if (level == 6'h00)
               next_state = ST_OFF;
            else if (qtick)
               next_level = level - 6'h01;
         end
         default:
            next_state = ST_OFF;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state     <= ST_OFF;
         level     <= 6'h00;
         blank_cnt <= 5'h00;
         fall_wait <= 2'h0;
         pg_timer  <= 18'h0_0000;
      end
      else
      begin
         state     <= next_state;
         level     <= next_level;
         blank_cnt <= next_blank_cnt;
         fall_wait <= next_fall_wait;
         pg_timer  <= next_pg_timer;
      end
   end

   // Fault latch; a new fault wins over clearing.
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         fault_latched <= 1'b0;
      else if (hw_fault & ~state[0])
         fault_latched <= 1'b1;
      else if (~power_down_n | nofault)
         fault_latched <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         dac_level            <= 6'h00;
         regulator_enable     <= 1'b0;
         low_side_gate        <= 1'b1;
         high_side_gate       <= 1'b0;
         power_good           <= 1'b0;
         pulse_skip           <= 1'b0;
         pg_upper_blank       <= 1'b0;
         offset_enable        <= 1'b0;
         offset_window        <= `SVM_OFS_NONE;
         on_time_mode         <= `SVM_LVL_OPEN;
         undervoltage_protect <= 1'b0;
      end
      else
      begin
         dac_level <= next_level;
         // Off state forces low gate high, high gate low.
         regulator_enable <= ~next_state[0];
         low_side_gate    <= next_state[0];
         high_side_gate   <= 1'b0;
         // Pg drops at once outside the run state.
         // Pg low during the power-up delay.
         if (~power_down_n | ~state[2] | ~next_state[2])
            power_good <= 1'b0;
         else if (~blanked & (pg_timer == 18'h0_0000))
            power_good <= pg_eval;
         // Vcc on skip select runs forced PWM.
         // Ground or reference selects pulse skipping.
         pulse_skip     <= (pulse_skip_select == `SVM_LVL_GND) | (pulse_skip_select == `SVM_LVL_REF);
         pg_upper_blank <= (pulse_skip_select == `SVM_LVL_GND) | (pulse_skip_select == `SVM_LVL_REF);
         // Deep sleep offset only with suspend at ground.
         offset_enable <= ~suspend & (offset_input != `SVM_OFS_NONE);
         offset_window <= suspend ? `SVM_OFS_NONE : offset_input;
         // Static four-level input passed as decoded.
         on_time_mode <= on_time_select;
         undervoltage_protect <= state[2] & ~blanked & ~nofault;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register slave answers one cycle after a request is seen, so the
   // master never sees a combinational path from address to waitrequest.
   assign status_word = {4'h0, on_time_mode, state, 4'h0, fault_latched, power_good,
                         2'h0, target, 2'h0, level};

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
         nofault         <= 1'b0;
      end
      else
      begin
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
         if (avs_read & avs_waitrequest)
         begin
            case (avs_address)
               `SVM_REG_STATUS: avs_readdata <= status_word;
               `SVM_REG_LEVEL:  avs_readdata <= {26'h000_0000, level};
               `SVM_REG_CTRL:   avs_readdata <= {31'h0000_0000, nofault};
               default:         avs_readdata <= 32'h0000_0000;
            endcase
         end
         if (avs_write & ~avs_waitrequest & (avs_address == `SVM_REG_CTRL))
            nofault <= avs_writedata[`SVM_CTRL_NOFAULT];
      end
   end

endmodule // svm_vid_slew_mode_controller

`default_nettype wire

// ===== dv/svm_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module svm_cpu_model
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [5:0] req_vid,
   output var  logic [5:0] vid_code,
   output wire logic       pg_low_ok,
   output wire logic       pg_high_ok
);
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         vid_code <= 6'h00;
      end
      else
      begin
         vid_code <= req_vid;
      end
   end
   // The output is taken as inside its window.
   assign pg_low_ok = 1'b1;
   assign pg_high_ok = 1'b1;
endmodule // svm_cpu_model
`default_nettype wire

// ===== dv/svm_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module svm_chk
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       power_down_n,
   input wire logic [1:0] suspend_select,
   input wire logic [1:0] pulse_skip_select,
   input wire logic       avs_read,
   input wire logic       avs_write,
   input wire logic       avs_waitrequest,
   input wire logic [5:0] dac_level,
   input wire logic       regulator_enable,
   input wire logic       low_side_gate,
   input wire logic       high_side_gate,
   input wire logic       power_good,
   input wire logic       pulse_skip,
   input wire logic       pg_upper_blank,
   input wire logic       offset_enable,
   input wire logic       fault_latched
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_pd_pg_drop: assert property (!power_down_n |=> !power_good) else $error("pg high in shutdown");
   a_hs_gate_off: assert property (!high_side_gate) else $error("high gate driven");
   a_skip_follow: assert property ((pulse_skip_select <= 2'h1) |=> pulse_skip && pg_upper_blank)
      else $error("skip mode not entered");
   a_sus_no_offset: assert property (suspend_select != 2'h0 |=> !offset_enable)
      else $error("offset on in suspend");
   a_single_step: assert property ($changed(dac_level) |->
      (dac_level == $past(dac_level) + 6'h01) || (dac_level == $past(dac_level) - 6'h01))
      else $error("level jumped");
   a_low_gate_zero: assert property (low_side_gate |-> dac_level == 6'h00 && !regulator_enable)
      else $error("low gate forced early");
   a_pg_frozen: assert property ($changed(dac_level) && power_down_n && !fault_latched |-> $stable(power_good))
      else $error("pg moved while slewing");
   a_fault_held: assert property (fault_latched && power_down_n && !avs_write |=> fault_latched)
      else $error("fault latch lost");
   a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer late");
   c_pg_up: cover property ($rose(power_good));
   c_fault: cover property ($rose(fault_latched));
   c_skip: cover property ($rose(pulse_skip));
endmodule // svm_chk
bind svm_vid_slew_mode_controller svm_chk u_chk (.clk(clk), .rst(rst), .power_down_n(power_down_n),
   .suspend_select(suspend_select), .pulse_skip_select(pulse_skip_select), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .dac_level(dac_level),
   .regulator_enable(regulator_enable), .low_side_gate(low_side_gate), .high_side_gate(high_side_gate),
   .power_good(power_good), .pulse_skip(pulse_skip), .pg_upper_blank(pg_upper_blank),
   .offset_enable(offset_enable), .fault_latched(fault_latched));
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "svm_defs.vh"
module tb_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        power_down_n = 1'b0;
   logic [5:0]  req_vid = 6'h04;
   logic [5:0]  vid_code;
   logic [1:0]  suspend_select = 2'h0;
   logic [3:0]  suspend_code_sel = 4'h0;
   logic [1:0]  on_time_select = 2'h1;
   logic [1:0]  pulse_skip_select = 2'h3;
   logic [1:0]  offset_input = 2'h0;
   logic [7:0]  slew_rate_resistor = 8'h0f;
   logic        pg_low_ok;
   logic        pg_high_ok;
   logic        uv = 1'b0;
   logic        ov = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic [31:0] rd;
   logic        avs_waitrequest;
   logic [5:0]  dac_level;
   logic        regulator_enable, low_side_gate, high_side_gate, power_good;
   logic        pulse_skip, pg_upper_blank, offset_enable, undervoltage_protect, fault_latched;
   logic [1:0]  offset_window, on_time_mode;
   int          err_total = 0;
   int          cmp_count = 0;
   int          n;
   always #10 clk = ~clk;
   svm_cpu_model u_cpu (.clk, .rst, .req_vid, .vid_code, .pg_low_ok, .pg_high_ok);
   // Short power-good delay keeps the run brief.
   svm_vid_slew_mode_controller #(.PG_DELAY_CYC(18'd200)) DUT (.clk, .rst, .power_down_n, .vid_code,
      .suspend_select, .suspend_code_sel, .on_time_select, .pulse_skip_select, .offset_input,
      .slew_rate_resistor, .pg_low_ok, .pg_high_ok, .undervoltage_detect(uv), .overvoltage_detect(ov),
      .thermal_detect(1'b0), .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .dac_level, .regulator_enable, .low_side_gate, .high_side_gate, .power_good,
      .pulse_skip, .pg_upper_blank, .offset_enable, .offset_window, .on_time_mode,
      .undervoltage_protect, .fault_latched);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic chk_rng(input int v, input int lo, input int hi);
      cmp_count++;
      if (v < lo || v > hi)
      begin
         err_total++;
         $display("unexpected at %0t: %0d cycles outside %0d..%0d", $time, v, lo, hi);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= wd;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (avs_waitrequest !== 1'b0 && k < 50);
      if (k >= 50)
         err_total++;
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_lvl(input logic [5:0] l);
      n = 0;
      while (dac_level !== l && n < 20000)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 20000)
         err_total++;
   endtask
   task automatic summarize();
      if (err_total == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (60000) @(posedge clk);
      err_total++;
      summarize();
   end
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      chk({low_side_gate, high_side_gate, power_good, regulator_enable}, 4'b1000);
      bus(1'b0, `SVM_REG_STATUS, 32'h0000_0000);
      chk(rd[27:22], 6'b01_0001);
      chk(on_time_mode, 2'h1);
      bus(1'b0, 4'hc, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      bus(1'b1, `SVM_REG_CTRL, 32'h0000_0001);
      bus(1'b0, `SVM_REG_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      bus(1'b1, `SVM_REG_CTRL, 32'h0000_0000);
      power_down_n <= 1'b1;
      wait_lvl(6'h04);
      chk_rng(n, 600, 900);
      repeat (1100) @(posedge clk);
      chk(power_good, 1'b0);
      wait_lvl(6'h04);
      for (n = 0; power_good !== 1'b1 && n < 400; n++) @(posedge clk);
      chk(power_good, 1'b1);
      bus(1'b0, `SVM_REG_LEVEL, 32'h0000_0000);
      chk(rd, 32'h0000_0004);
      req_vid <= 6'h08;
      wait_lvl(6'h08);
      chk_rng(n, 140, 260);
      req_vid <= 6'h04;
      wait_lvl(6'h04);
      chk_rng(n, 240, 360);
      slew_rate_resistor <= 8'h96;
      req_vid <= 6'h06;
      wait_lvl(6'h06);
      chk_rng(n, 480, 1100);
      slew_rate_resistor <= 8'h0f;
      pulse_skip_select <= 2'h0;
      offset_input <= 2'h1;
      repeat (3) @(posedge clk);
      chk({pulse_skip, pg_upper_blank, offset_enable, offset_window}, 5'b11101);
      pulse_skip_select <= 2'h1;
      offset_input <= 2'h2;
      repeat (3) @(posedge clk);
      chk({pulse_skip, pg_upper_blank, offset_enable, offset_window}, 5'b11110);
      pulse_skip_select <= 2'h3;
      suspend_select <= 2'h1;
      wait_lvl(`SVM_SUS_HI_BASE);
      chk_rng(n, 840, 1060);
      chk({pulse_skip, offset_enable, offset_window}, 4'b0000);
      suspend_select <= 2'h2;
      wait_lvl(`SVM_SUS_LO_BASE);
      chk_rng(n, 840, 1060);
      suspend_select <= 2'h0;
      offset_input <= 2'h0;
      req_vid <= 6'h08;
      repeat (20) @(posedge clk);
      uv <= 1'b1;
      repeat (3) @(posedge clk);
      uv <= 1'b0;
      wait_lvl(6'h08);
      chk(fault_latched, 1'b0);
      chk(undervoltage_protect, 1'b0);
      repeat (1400) @(posedge clk);
      chk(undervoltage_protect, 1'b1);
      uv <= 1'b1;
      repeat (3) @(posedge clk);
      chk(fault_latched, 1'b1);
      uv <= 1'b0;
      wait_lvl(6'h00);
      repeat (3) @(posedge clk);
      chk({low_side_gate, high_side_gate, regulator_enable, fault_latched}, 4'b1001);
      power_down_n <= 1'b0;
      repeat (3) @(posedge clk);
      power_down_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk(fault_latched, 1'b0);
      wait_lvl(6'h08);
      power_down_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk(power_good, 1'b0);
      wait_lvl(6'h00);
      chk_rng(n, 1300, 1700);
      repeat (3) @(posedge clk);
      chk({low_side_gate, high_side_gate, regulator_enable}, 3'b100);
      power_down_n <= 1'b1;
      repeat (5) @(posedge clk);
      ov <= 1'b1;
      repeat (3) @(posedge clk);
      chk(fault_latched, 1'b1);
      ov <= 1'b0;
      summarize();
   end
endmodule // tb_top
`default_nettype wire
